// [hw/tmwm_pkg.sv]
// Package: register map, field positions and mode encodings for the timer
package tmwm_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] TMWM_OFF_CTRL_A = 4'h0;
    localparam logic [3:0] TMWM_OFF_CTRL_B = 4'h4;
    localparam logic [3:0] TMWM_OFF_COMP_A = 4'h8;
    localparam logic [3:0] TMWM_OFF_COMP_B = 4'hC;
    localparam logic [3:0] TMWM_OFF_CAPT = 4'h0;
    localparam logic [5:0] TMWM_OFF_CAPT_W = 6'h10;
    localparam logic [5:0] TMWM_OFF_STAT = 6'h14;
    // Control register A field positions
    localparam int TMWM_A_MODE_A = 6;
    localparam int TMWM_A_MODE_B = 4;
    localparam int TMWM_A_FORCE_A = 3;
    localparam int TMWM_A_FORCE_B = 2;
    localparam int TMWM_A_WAVE_LO = 0;
    // Control register B field positions
    localparam int TMWM_B_FILT_EN = 7;
    localparam int TMWM_B_EDGE_SEL = 6;
    localparam int TMWM_B_WAVE_HI = 3;
    localparam int TMWM_B_CLK_SEL = 0;
    // Reset values
    localparam logic [7:0] TMWM_RST_CTRL_A = 8'h00;
    localparam logic [7:0] TMWM_RST_CTRL_B = 8'h00;
    localparam logic [15:0] TMWM_RST_VAL = 16'h0000;
    // Writable bit masks (force bits never stored, bit 5 of B reserved)
    localparam logic [7:0] TMWM_MASK_A = 8'hF3;
    localparam logic [7:0] TMWM_MASK_B = 8'hDF;
    // Fixed TOP values and MAX
    localparam logic [15:0] TMWM_TOP_8 = 16'h00FF;
    localparam logic [15:0] TMWM_TOP_9 = 16'h01FF;
    localparam logic [15:0] TMWM_TOP_10 = 16'h03FF;
    localparam logic [15:0] TMWM_MAX = 16'hFFFF;
    // Filter sample count
    localparam int TMWM_FILT_LEN = 4;
    // Prescale dividers
    localparam logic [9:0] TMWM_DIV_8 = 10'h007;
    localparam logic [9:0] TMWM_DIV_64 = 10'h03F;
    localparam logic [9:0] TMWM_DIV_256 = 10'h0FF;
    localparam logic [9:0] TMWM_DIV_1024 = 10'h3FF;
    // AXI responses
    localparam logic [1:0] TMWM_RESP_OK = 2'b00;
    localparam logic [1:0] TMWM_RESP_ERR = 2'b10;
    // Output action on a compare or BOTTOM event
    typedef enum logic [1:0] {
        TMWM_ACT_NONE = 2'b00,
        TMWM_ACT_TOG = 2'b01,
        TMWM_ACT_CLR = 2'b10,
        TMWM_ACT_SET = 2'b11
    } tmwm_act_t;
    // Counting family decoded from the mode select
    typedef enum logic [1:0] {
        TMWM_FAM_NORM = 2'b00,
        TMWM_FAM_FAST = 2'b01,
        TMWM_FAM_DUAL = 2'b11,
        TMWM_FAM_RSVD = 2'b10
    } tmwm_fam_t;
    // Decoded mode bundle
    typedef struct packed {
        tmwm_fam_t fam;
        logic pfc;
        logic [1:0] top_src;
    } tmwm_mode_t;
    // TOP sources
    localparam logic [1:0] TMWM_TOP_FIX = 2'd0;
    localparam logic [1:0] TMWM_TOP_CAP = 2'd1;
    localparam logic [1:0] TMWM_TOP_CMPA = 2'd2;
endpackage

// [hw/tmwm_capt_filt.sv]
// Capture input noise filter and edge detector
module tmwm_capt_filt
    import tmwm_pkg::*;
#(
    parameter int LEN = TMWM_FILT_LEN
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin,
    input wire logic filt_en,
    input wire logic edge_sel,
    output logic event_o
);
    // Sample history, filtered level, previous level
    logic [LEN-1:0] hist_q;
    logic filt_q;
    logic prev_q;
    wire all_hi = &hist_q;
    wire all_lo = ~|hist_q;
    // Level fed to edge detector: filtered or direct
    wire level = filt_en ? filt_q : hist_q[0];
    // Shift samples in, change filtered output on equal run
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_q <= '0;
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            hist_q <= {hist_q[LEN-2:0], pin};
            if (all_hi) begin // [RULE18] [RULE19]
                filt_q <= 1'b1;
            end else if (all_lo) begin
                filt_q <= 1'b0;
            end
            prev_q <= level;
        end
    end
    // Falling edge when select is zero, rising when one
    assign event_o = edge_sel ? (level & ~prev_q) : (~level & prev_q); // [RULE22]
endmodule

// [hw/tmwm_timer.sv]
// Timer top: AXI4-Lite registers, counter, mode decode, wave outputs
//
// What this block does
// RULE1: Output mode zero leaves pin disconnected
// RULE2: Fast PWM mode 01 toggles A only in 15
// RULE3: Fast PWM 10: clear on match, set BOTTOM
// RULE4: Fast PWM 11: set on match, clear BOTTOM
// RULE5: Fast PWM compare equals TOP: ignore match
// RULE6: Dual-slope 01 toggles A only modes 9,14; code toggles A in mode 9 only
// RULE7: Dual-slope 10: clear up, set down
// RULE8: Dual-slope 11: set up, clear down
// RULE9: Force bits act only in non-PWM modes
// RULE10: Force bit applies immediate match per mode
// RULE11: Force sets no flag, no counter clear
// RULE12: Force bits are write-only, read zero
// RULE13: Mode select from A[1:0], B[4:3]
// RULE14: Modes 0,4,12: immediate update, flag MAX
// RULE15: Phase correct: load TOP, flag BOTTOM
// RULE16: Fast PWM: load BOTTOM, flag TOP
// RULE17: Modes 8,9: load and flag BOTTOM
// RULE18: Filter needs four equal samples
// RULE19: Filter adds four cycles capture delay
// RULE20: Non-PWM: 01 toggle, 10 clear, 11 set
// RULE21: Clock select: stop, prescales, external edges
// RULE22: Edge select: zero falling, one rising
// RULE23: Software avoids reserved mode 13
module tmwm_timer
    import tmwm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [5:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [5:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CAPTURE_INPUT_PIN,
    input wire logic EXTERNAL_COUNT_INPUT,
    output logic WAVE_OUT_A,
    output logic WAVE_OUT_B,
    output logic WAVE_OUT_A_EN,
    output logic WAVE_OUT_B_EN,
    output logic OVERFLOW_FLAG
);
    // Control and value registers
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [15:0] cmp_a_buf_q, cmp_b_buf_q; // Software-written buffers
    logic [15:0] cmp_a_q, cmp_b_q; // Active compare values
    logic [15:0] capt_q; // Capture value
    logic [15:0] cnt_q; // Counter value
    logic down_q; // Counting down in dual-slope
    logic ovf_q; // Sticky overflow flag
    logic [9:0] pre_q; // Prescaler
    logic ext_q; // Previous external pin level
    logic wa_q, wb_q, wa_en_q, wb_en_q;
    // AXI handshake state
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q, arready_q;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // Field extraction
    wire [1:0] mode_a = ctrl_a_q[TMWM_A_MODE_A +: 2];
    wire [1:0] mode_b = ctrl_a_q[TMWM_A_MODE_B +: 2];
    wire [3:0] wsel = {ctrl_b_q[TMWM_B_WAVE_HI +: 2],
                       ctrl_a_q[TMWM_A_WAVE_LO +: 2]}; // [RULE13]
    wire [2:0] csel = ctrl_b_q[TMWM_B_CLK_SEL +: 3];

    // Mode decode table
    tmwm_mode_t md;
    always_comb begin
        md = '{fam: TMWM_FAM_NORM, pfc: 1'b0, top_src: TMWM_TOP_FIX};
        case (wsel) // [RULE14] [RULE15] [RULE16] [RULE17]
            4'd0: md.fam = TMWM_FAM_NORM;
            4'd1, 4'd2, 4'd3: md.fam = TMWM_FAM_DUAL;
            4'd4: md = '{TMWM_FAM_NORM, 1'b0, TMWM_TOP_CMPA};
            4'd5, 4'd6, 4'd7: md.fam = TMWM_FAM_FAST;
            4'd8: md = '{TMWM_FAM_DUAL, 1'b1, TMWM_TOP_CAP};
            4'd9: md = '{TMWM_FAM_DUAL, 1'b1, TMWM_TOP_CMPA};
            4'd10: md = '{TMWM_FAM_DUAL, 1'b0, TMWM_TOP_CAP};
            4'd11: md = '{TMWM_FAM_DUAL, 1'b0, TMWM_TOP_CMPA};
            4'd12: md = '{TMWM_FAM_NORM, 1'b0, TMWM_TOP_CAP};
            4'd14: md = '{TMWM_FAM_FAST, 1'b0, TMWM_TOP_CAP};
            4'd15: md = '{TMWM_FAM_FAST, 1'b0, TMWM_TOP_CMPA};
            default: md.fam = TMWM_FAM_RSVD; // [RULE23] counter holds
        endcase
    end

    // Fixed TOP from the low two mode bits
    logic [15:0] top_fix;
    always_comb begin
        case (wsel[1:0])
            2'd1: top_fix = TMWM_TOP_8;
            2'd2: top_fix = TMWM_TOP_9;
            2'd3: top_fix = TMWM_TOP_10;
            default: top_fix = TMWM_MAX;
        endcase
    end
    wire [15:0] top = (md.top_src == TMWM_TOP_CAP) ? capt_q :
                      (md.top_src == TMWM_TOP_CMPA) ? cmp_a_q : top_fix;

    // Prescaled timer tick selection
    wire ext_fall = ext_q & ~EXTERNAL_COUNT_INPUT;
    wire ext_rise = ~ext_q & EXTERNAL_COUNT_INPUT;
    logic tick;
    always_comb begin
        case (csel) // [RULE21]
            3'd1: tick = 1'b1;
            3'd2: tick = (pre_q[2:0] == TMWM_DIV_8[2:0]);
            3'd3: tick = (pre_q[5:0] == TMWM_DIV_64[5:0]);
            3'd4: tick = (pre_q[7:0] == TMWM_DIV_256[7:0]);
            3'd5: tick = (pre_q == TMWM_DIV_1024);
            3'd6: tick = ext_fall;
            3'd7: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // Counter events
    wire run = tick && (md.fam != TMWM_FAM_RSVD);
    wire dual = (md.fam == TMWM_FAM_DUAL);
    wire fast = (md.fam == TMWM_FAM_FAST);
    wire at_top = (cnt_q == top);
    wire at_bot = (cnt_q == 16'h0000);
    wire going_down = dual && (down_q || at_top); // Direction this tick
    wire [15:0] cnt_d = (!dual && at_top) ? 16'h0000 :
                        going_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    wire cnt_bot_next = run && (cnt_d == 16'h0000);
    wire match_a = run && (cnt_q == cmp_a_q);
    wire match_b = run && (cnt_q == cmp_b_q);

    // Buffer load points and overflow points
    wire load_now = (md.fam == TMWM_FAM_NORM) ||
                    (run && (fast || (dual && md.pfc)) && at_bot) ||
                    (run && dual && !md.pfc && at_top);
    // Dual-slope flag on the tick that lands the down-count on BOTTOM
    wire ovf_set = run && ( // [RULE14] [RULE15] [RULE16] [RULE17]
        (md.fam == TMWM_FAM_NORM && cnt_q == TMWM_MAX) ||
        (fast && at_top) ||
        (dual && going_down && cnt_d == 16'h0000));

    // Per-channel action on match, force or BOTTOM
    function automatic tmwm_act_t chan_act(input logic [1:0] om,
            input logic is_a, input logic match, input logic bot,
            input logic eq_top, input logic force_it);
        tmwm_act_t r;
        r = TMWM_ACT_NONE;
        if (om == 2'b00) begin
            r = TMWM_ACT_NONE; // [RULE1]
        end else if (fast) begin
            if (om == 2'b01) begin
                r = (is_a && wsel == 4'd15 && match) ?
                    TMWM_ACT_TOG : TMWM_ACT_NONE; // [RULE2]
            end else if (match && !eq_top) begin
                r = om[0] ? TMWM_ACT_SET : TMWM_ACT_CLR; // [RULE3] [RULE4]
            end else if (bot) begin
                r = om[0] ? TMWM_ACT_CLR : TMWM_ACT_SET; // [RULE5]
            end
        end else if (dual) begin
            if (om == 2'b01) begin
                r = (is_a && (wsel == 4'd9 || wsel == 4'd14) && match) ?
                    TMWM_ACT_TOG : TMWM_ACT_NONE; // [RULE6]
            end else if (match) begin
                r = (om[0] ^ going_down) ? TMWM_ACT_SET :
                    TMWM_ACT_CLR; // [RULE7] [RULE8]
            end
        end else if (md.fam == TMWM_FAM_NORM && (match || force_it)) begin
            r = tmwm_act_t'(om); // [RULE20] [RULE10]
        end
        return r;
    endfunction

    // Force strobes from a register A write (non-PWM only)
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire wr_a = wr_fire && awaddr_q == {2'b00, TMWM_OFF_CTRL_A} &&
                wstrb_q[0];
    wire non_pwm = (md.fam == TMWM_FAM_NORM);
    wire force_a = wr_a && non_pwm && wdata_q[TMWM_A_FORCE_A]; // [RULE9]
    wire force_b = wr_a && non_pwm && wdata_q[TMWM_A_FORCE_B]; // [RULE9]

    tmwm_act_t act_a, act_b;
    assign act_a = chan_act(mode_a, 1'b1, match_a, cnt_bot_next,
                            cmp_a_q == top, force_a);
    assign act_b = chan_act(mode_b, 1'b0, match_b, cnt_bot_next,
                            cmp_b_q == top, force_b);

    // Capture events from the filtered pin; disabled when capture is TOP
    logic capt_evt;
    tmwm_capt_filt #(.LEN(TMWM_FILT_LEN)) u_filt (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .pin(CAPTURE_INPUT_PIN),
        .filt_en(ctrl_b_q[TMWM_B_FILT_EN]),
        .edge_sel(ctrl_b_q[TMWM_B_EDGE_SEL]),
        .event_o(capt_evt)
    );
    wire capt_take = capt_evt && (md.top_src != TMWM_TOP_CAP);

    // Counter, direction, prescaler and external edge sampling
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q <= TMWM_RST_VAL;
            down_q <= 1'b0;
            pre_q <= '0;
            ext_q <= 1'b0;
        end else begin
            pre_q <= (csel == 3'd0) ? '0 : pre_q + 10'd1;
            ext_q <= EXTERNAL_COUNT_INPUT;
            if (run) begin
                cnt_q <= cnt_d; // [RULE11] force never clears it
                down_q <= dual && (cnt_d != 16'h0000) && going_down;
            end
        end
    end

    // Compare buffers, active values and capture register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_a_q <= TMWM_RST_VAL;
            cmp_b_q <= TMWM_RST_VAL;
            capt_q <= TMWM_RST_VAL;
        end else begin
            if (load_now) begin
                cmp_a_q <= cmp_a_buf_q;
                cmp_b_q <= cmp_b_buf_q;
            end
            if (capt_take) begin
                capt_q <= cnt_q;
            end else if (wr_fire && awaddr_q == TMWM_OFF_CAPT_W) begin
                capt_q <= wdata_q[15:0];
            end
        end
    end

    // Wave output flops; enables follow nonzero output mode, but 01 in PWM modes enables A only in modes 9 and 15
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wa_q <= 1'b0;
            wb_q <= 1'b0;
            wa_en_q <= 1'b0;
            wb_en_q <= 1'b0;
        end else begin
            case (act_a)
                TMWM_ACT_TOG: wa_q <= ~wa_q;
                TMWM_ACT_CLR: wa_q <= 1'b0;
                TMWM_ACT_SET: wa_q <= 1'b1;
                default: wa_q <= wa_q;
            endcase
            case (act_b)
                TMWM_ACT_TOG: wb_q <= ~wb_q;
                TMWM_ACT_CLR: wb_q <= 1'b0;
                TMWM_ACT_SET: wb_q <= 1'b1;
                default: wb_q <= wb_q;
            endcase
            // Channel B is disconnected for output mode 01 in PWM modes
            wa_en_q <= (mode_a != 2'b00) && !(mode_a == 2'b01 &&
                ((fast && wsel != 4'd15) ||
                 (dual && wsel != 4'd9 && wsel != 4'd14))); // [RULE1]
            wb_en_q <= (mode_b != 2'b00) &&
                       !(mode_b == 2'b01 && (fast || dual)); // [RULE2]
        end
    end

    // Overflow flag: set wins over clear by writing one
    wire ovf_clr = wr_fire && awaddr_q == TMWM_OFF_STAT && wdata_q[0];
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
        end
    end

    // AXI write channel capture
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (S_AXI_AWVALID && !aw_got_q) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (S_AXI_WVALID && !w_got_q) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Register writes and write response
    wire wr_map = awaddr_q[1:0] == 2'b00 && awaddr_q <= TMWM_OFF_STAT;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_a_q <= TMWM_RST_CTRL_A;
            ctrl_b_q <= TMWM_RST_CTRL_B;
            cmp_a_buf_q <= TMWM_RST_VAL;
            cmp_b_buf_q <= TMWM_RST_VAL;
            bvalid_q <= 1'b0;
            bresp_q <= TMWM_RESP_OK;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? TMWM_RESP_OK : TMWM_RESP_ERR;
                if (wstrb_q[0] && awaddr_q[5:4] == 2'b00) begin
                    case (awaddr_q[3:0])
                        TMWM_OFF_CTRL_A:
                            ctrl_a_q <= wdata_q[7:0] & TMWM_MASK_A; // [RULE12]
                        TMWM_OFF_CTRL_B:
                            ctrl_b_q <= wdata_q[7:0] & TMWM_MASK_B;
                        TMWM_OFF_COMP_A: cmp_a_buf_q[7:0] <= wdata_q[7:0];
                        TMWM_OFF_COMP_B: cmp_b_buf_q[7:0] <= wdata_q[7:0];
                        default: ;
                    endcase
                end
                if (wstrb_q[1] && awaddr_q == {2'b00, TMWM_OFF_COMP_A}) begin
                    cmp_a_buf_q[15:8] <= wdata_q[15:8];
                end
                if (wstrb_q[1] && awaddr_q == {2'b00, TMWM_OFF_COMP_B}) begin
                    cmp_b_buf_q[15:8] <= wdata_q[15:8];
                end
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read decode
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            {2'b00, TMWM_OFF_CTRL_A}: rd_val = {24'h0000_00, ctrl_a_q};
            {2'b00, TMWM_OFF_CTRL_B}: rd_val = {24'h0000_00, ctrl_b_q};
            {2'b00, TMWM_OFF_COMP_A}: rd_val = {16'h0000, cmp_a_buf_q};
            {2'b00, TMWM_OFF_COMP_B}: rd_val = {16'h0000, cmp_b_buf_q};
            TMWM_OFF_CAPT_W: rd_val = {16'h0000, capt_q};
            TMWM_OFF_STAT: rd_val = {cnt_q, 15'h0000, ovf_q};
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read channel: one read in flight
    wire rd_take = S_AXI_ARVALID && arready_q;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= TMWM_RESP_OK;
        end else if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? TMWM_RESP_OK : TMWM_RESP_ERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Outputs straight from flops
    assign S_AXI_AWREADY = ~aw_got_q;
    assign S_AXI_WREADY = ~w_got_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign WAVE_OUT_A = wa_q;
    assign WAVE_OUT_B = wb_q;
    assign WAVE_OUT_A_EN = wa_en_q;
    assign WAVE_OUT_B_EN = wb_en_q;
    assign OVERFLOW_FLAG = ovf_q;
endmodule

// [tb/tmwm_timer_checker.sv]
// Checker: bus handshake, read-back and pin ownership of the timer
module tmwm_timer_checker
    import tmwm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [5:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [5:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic WAVE_OUT_A_EN,
    input wire logic WAVE_OUT_B_EN,
    input wire logic OVERFLOW_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic [7:0] ctl_q; // Shadow of control A
    logic [5:0] ra_q; // Address of the read in flight
    logic [2:0] age_q; // Cycles since a write, saturating
    wire aw_go = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_go = S_AXI_WVALID && S_AXI_WREADY;
    // Track control A, read address and write age
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_q <= 8'h00;
            ra_q <= 6'h00;
            age_q <= 3'd7;
        end else begin
            if (aw_go && w_go && S_AXI_AWADDR == 6'h00)
                ctl_q <= S_AXI_WDATA[7:0];
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                ra_q <= S_AXI_ARADDR;
            age_q <= aw_go ? 3'd0 : age_q + {2'b00, age_q != 3'd7};
        end
    end
    sequence s_wr_take;
        aw_go && w_go;
    endsequence
    sequence s_rd_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##[1:3] S_AXI_BVALID)
        else $error("write response missing");
    a_rd_answer: assert property (s_rd_take |-> ##[1:3] S_AXI_RVALID)
        else $error("read response missing");
    a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");
    a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read dropped");
    a_force_reads_zero: assert property (
        S_AXI_RVALID && ra_q == 6'h00 |-> S_AXI_RDATA[3:2] == 2'b00)
        else $error("force bits read as one");
    a_unmapped_err: assert property (S_AXI_RVALID && ra_q > TMWM_OFF_STAT
        |-> S_AXI_RRESP == TMWM_RESP_ERR && S_AXI_RDATA == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_a_disconnect: assert property (
        age_q == 3'd7 && ctl_q[7:6] == 2'b00 |-> !WAVE_OUT_A_EN)
        else $error("channel A pin owned with mode zero");
    a_b_disconnect: assert property (
        age_q == 3'd7 && ctl_q[5:4] == 2'b00 |-> !WAVE_OUT_B_EN)
        else $error("channel B pin owned with mode zero");
    a_flag_sticky: assert property ($fell(OVERFLOW_FLAG) |-> age_q < 3'd4)
        else $error("overflow flag fell without a write");
endmodule
bind tmwm_timer tmwm_timer_checker u_chk (.*);

// [tb/tmwm_timer_tb.sv]
// Testbench: registers, output modes, force strobes and PWM duty
module tmwm_timer_tb
    import tmwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK, ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_RREADY, CAPTURE_INPUT_PIN;
    logic EXTERNAL_COUNT_INPUT, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, OVERFLOW_FLAG;
    logic WAVE_OUT_A, WAVE_OUT_B, WAVE_OUT_A_EN, WAVE_OUT_B_EN;
    logic [5:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
    logic [3:0] S_AXI_WSTRB, m;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rrsp, om, brsp;
    logic w0;
    int failures, n_compared, hi, c;
    tmwm_timer u_dut (.*);
    // Clock at 25 MHz
    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bus write, both channels offered together
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        brsp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    // Bus read
    task automatic rd(input logic [5:0] a);
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        rdat = S_AXI_RDATA;
        rrsp = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
    // Pin ownership with output mode 01
    function automatic logic en_exp(logic [3:0] md, logic is_a);
        if (md == 4'd0 || md == 4'd4 || md == 4'd12) return 1'b1;
        return is_a && (md == 4'd9 || md == 4'd14 || md == 4'd15);
    endfunction
    // High cycles in a window of four fast-PWM or two dual-slope periods
    function automatic int hi_exp(logic [3:0] md, logic [1:0] o, int v);
        int h;
        int w;
        w = (md == 4'd5) ? 1024 : 1020;
        h = (md == 4'd5) ? ((v == 255) ? 1024 : 4 * (v + 1)) : 4 * v;
        return (o == 2'b11) ? w - h : h;
    endfunction
    // Watchdog
    initial begin
        repeat (40000) @(posedge CORE_CLK);
        failures++;
        results();
    end
    // Main sequence
    initial begin
        failures = 0;
        n_compared = 0;
        {ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h0;
        {S_AXI_ARVALID, S_AXI_RREADY, CAPTURE_INPUT_PIN} = 3'h0;
        EXTERNAL_COUNT_INPUT = 1'b0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        S_AXI_WSTRB = 4'hF;
        void'($urandom(10452));
        repeat (4) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        for (int a = 0; a < 24; a += 4) begin
            rd(6'(a));
            check(rdat, 32'h0000_0000);
        end
        wr(6'h18, 32'h0000_0001);
        check({30'h0, brsp}, {30'h0, TMWM_RESP_ERR});
        rd(6'h18);
        check({30'h0, rrsp}, {30'h0, TMWM_RESP_ERR});
        wr(6'h00, 32'h0000_00FF);
        rd(6'h00);
        check(rdat, 32'h0000_00F3);
        wr(6'h04, 32'h0000_00FF);
        rd(6'h04);
        check(rdat, 32'h0000_00DF);
        for (int k = 0; k < 7; k++) begin
            m = 4'(k * 3 % 16); // never 13
            if (k == 6) m = 4'd9;
            wr(6'h04, {27'h0, m[3:2], 3'b000});
            wr(6'h00, {24'h0, 6'h14, m[1:0]});
            repeat (3) @(posedge CORE_CLK);
            check(WAVE_OUT_A_EN, en_exp(m, 1'b1));
            check(WAVE_OUT_B_EN, en_exp(m, 1'b0));
        end
        wr(6'h04, 32'h0000_0000);
        for (int k = 1; k < 4; k++) begin
            om = 2'(k);
            w0 = WAVE_OUT_A;
            wr(6'h00, {24'h0, om, om, 4'h0});
            wr(6'h00, {24'h0, om, om, 4'hC});
            repeat (2) @(posedge CORE_CLK);
            check(WAVE_OUT_A, (k == 1) ? !w0 : om[0]);
            check(WAVE_OUT_B, (k == 1) ? !w0 : om[0]);
            check(OVERFLOW_FLAG, 1'b0);
        end
        wr(6'h04, 32'h0000_0008);
        wr(6'h00, 32'h0000_0081);
        wr(6'h00, 32'h0000_0089);
        repeat (2) @(posedge CORE_CLK);
        check(WAVE_OUT_A, 1'b1);
        for (int k = 0; k < 6; k++) begin
            m = (k < 4) ? 4'd5 : 4'd1;
            om = 2'(2 + k % 2);
            c = (k == 2 || k == 3) ? 255 : 1 + $urandom % 254;
            wr(6'h04, 32'h0000_0000);
            wr(6'h14, 32'h0000_0001);
            wr(6'h08, 32'(c));
            wr(6'h00, {24'h0, om, 6'h01});
            wr(6'h04, {27'h0, m[3:2], 3'b001});
            repeat (600) @(posedge CORE_CLK);
            hi = 0;
            repeat ((m == 4'd5) ? 1024 : 1020) begin
                @(posedge CORE_CLK);
                hi += (WAVE_OUT_A === 1'b1);
            end
            check(hi, hi_exp(m, om, c));
            check(OVERFLOW_FLAG, 1'b1);
        end
        results();
    end
endmodule
